// ---- core/serial_mode_pkg.sv ----
// Purpose: Shared constants for the serial personality selector
// Assumes: 32-bit register bus, byte addresses as printed
// Notes:   Config and data words sit beside the mode words

package serial_mode_pkg;

    // Personality codes held in the two-bit mode field
    typedef enum logic [1:0] {
        PERS_OFF  = 2'h0,
        PERS_UART = 2'h1,
        PERS_SPI  = 2'h2,
        PERS_TWI  = 2'h3
    } personality_e;

    // Register byte addresses
    localparam logic [31:0] ADDR_ONE_MODE = 32'h4000_C854;
    localparam logic [31:0] ADDR_TWO_MODE = 32'h4000_C054;
    localparam logic [31:0] ADDR_ONE_CFG  = 32'h4000_C858;
    localparam logic [31:0] ADDR_TWO_CFG  = 32'h4000_C058;
    localparam logic [31:0] ADDR_ONE_DATA = 32'h4000_C85C;
    localparam logic [31:0] ADDR_TWO_DATA = 32'h4000_C05C;

    // Reset values
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [5:0] CFG_RST  = 6'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // Config word fields
    localparam int CFG_SLAVE    = 0;   // SPI slave when set
    localparam int CFG_FLOW     = 1;   // RTS/CTS flow control
    localparam int CFG_FIFODMA  = 2;   // Request FIFO and DMA use
    localparam int CFG_RXLVL    = 3;   // Rx-available trigger style
    localparam int CFG_TXFRLVL  = 4;   // Tx-free trigger style
    localparam int CFG_TXIDLVL  = 5;   // Tx-idle trigger style
    localparam int CFG_W        = 6;
    localparam int STAT_FIFODMA = 8;   // Read-only: FIFO/DMA granted

    // Field widths
    localparam int MODE_W = 2;
    localparam int DATA_W = 8;
    localparam int PINS_W = 4;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- core/pin_route_if.sv ----
// Purpose: Carries one unit's config, engine lines and pins to its mux
// Assumes: Pin inputs arrive already synchronised
// Notes:   Open-drain lines are requested low by the engine

`timescale 1ns/1ps

interface pin_route_if;
    import serial_mode_pkg::*;
    personality_e      pers;      // Active personality
    logic              slave;     // SPI slave select
    logic              flowEn;    // Flow control enable
    logic              dataOut;   // Engine serial data out
    logic              clkOut;    // Engine serial clock out
    logic              rtsN;      // Engine request-to-send, low active
    logic              sdaLow;    // Engine pulls two-wire data low
    logic              sclLow;    // Engine pulls two-wire clock low
    logic [PINS_W-1:0] pinIn;     // Synchronised pin levels
    logic [PINS_W-1:0] pinOut;    // Pin drive values
    logic [PINS_W-1:0] pinOe;     // Pin drive enables
    logic              dataIn;    // Serial data to engine
    logic              clkIn;     // Serial clock to engine
    logic              selN;      // Slave select to engine, low active
    logic              ctsN;      // Clear-to-send to engine, low active
    logic              sdaIn;     // Two-wire data level to engine
    logic              sclIn;     // Two-wire clock level to engine

    modport mux (
        input  pers, slave, flowEn, dataOut, clkOut, rtsN, sdaLow, sclLow, pinIn,
        output pinOut, pinOe, dataIn, clkIn, selN, ctsN, sdaIn, sclIn
    );
    modport top (
        output pers, slave, flowEn, dataOut, clkOut, rtsN, sdaLow, sclLow, pinIn,
        input  pinOut, pinOe, dataIn, clkIn, selN, ctsN, sdaIn, sclIn
    );
endinterface

// ---- core/pin_sync.sv ----
// Purpose: Two-stage synchroniser for asynchronous pin levels
// Assumes: Inputs are quasi-static against clk
// Notes:   Stage one feeds stage two only

`timescale 1ns/1ps

module pin_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] meta_r;    // First stage, metastability catcher
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;    // Second stage, safe to use
    logic [W-1:0] sync_nxt;

    // Next values; idle pins read high after reset
    always_comb begin
        meta_nxt = asyncIn;
        sync_nxt = meta_r;
        if (!rst_n) begin
            meta_nxt = '1;
            sync_nxt = '1;
        end
    end

    // Register both stages
    always_ff @(posedge clk) begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign syncOut = sync_r;
endmodule

// ---- core/unit_pin_mux.sv ----
// Purpose: Routes one serial unit's functions onto its four pins
// Assumes: Local pin 0..3 is the unit's first..fourth pin
// Notes:   TWI_BASE shifts the two-wire pair; UART_OK gates UART

`timescale 1ns/1ps

module unit_pin_mux
    import serial_mode_pkg::*;
#(
    parameter bit UART_OK  = 1'b1,
    parameter int TWI_BASE = 0
) (
    pin_route_if.mux rt
);
    // Personality decides pin direction and drive style
    always_comb begin
        rt.pinOut = '0;
        rt.pinOe  = '0;
        rt.dataIn = 1'b1;     // Idle levels while unused
        rt.clkIn  = 1'b0;
        rt.selN   = 1'b1;
        rt.ctsN   = 1'b1;
        rt.sdaIn  = 1'b1;
        rt.sclIn  = 1'b1;
        case (rt.pers)
            PERS_SPI: begin
                rt.pinOut[0] = rt.dataOut;
                rt.pinOe[0]  = 1'b1;
                rt.dataIn    = rt.pinIn[1];
                if (rt.slave) begin
                    rt.clkIn = rt.pinIn[2];
                    rt.selN  = rt.pinIn[3];
                end else begin
                    rt.pinOut[2] = rt.clkOut;
                    rt.pinOe[2]  = 1'b1;
                end
            end
            PERS_TWI: begin
                // Open drain: drive low only, never high
                rt.pinOe[TWI_BASE]   = rt.sdaLow;
                rt.pinOe[TWI_BASE+1] = rt.sclLow;
                rt.sdaIn = rt.pinIn[TWI_BASE];
                rt.sclIn = rt.pinIn[TWI_BASE+1];
            end
            PERS_UART: begin
                if (UART_OK) begin
                    rt.pinOut[0] = rt.dataOut;
                    rt.pinOe[0]  = 1'b1;
                    rt.dataIn    = rt.pinIn[1];
                    if (rt.flowEn) begin
                        rt.ctsN      = rt.pinIn[2];
                        rt.pinOut[3] = rt.rtsN;
                        rt.pinOe[3]  = 1'b1;
                    end
                end
            end
            default: begin
                // Disabled: pins released, inputs ignored
                rt.pinOe = '0;
            end
        endcase
    end
endmodule

// ---- core/serial_controller_mode_select.sv ----
// Purpose: Mode registers and pin routing for two serial units
// Assumes: AXI4-Lite slave on clk; engines sit outside this block
// Notes:   Pin outputs are registered; pin inputs synchronised
//
// Summary of operation
// - Two independent serial units, mode per unit
// - Two-wire mode is bus master only
// - UART exists on unit one only
// - FIFO and DMA only in SPI, UART
// - Software may poll data registers directly
// - Mode codes: off, UART, SPI, two-wire
// - Unit one SPI master pin mapping
// - Unit one SPI slave pin mapping
// - Unit one two-wire open-drain pins
// - Unit one UART data pins
// - UART CTS/RTS pins when flow enabled
// - Unit two SPI master pin mapping
// - Unit two two-wire open-drain pins
// - Trigger style bit: 0 edge, 1 level

`timescale 1ns/1ps

module serial_controller_mode_select
    import serial_mode_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    // AXI4-Lite slave
    input  wire logic [31:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [31:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Unit one pins (second to fifth pin of port B)
    input  wire logic [PINS_W-1:0] portBIn,
    output logic      [PINS_W-1:0] portBOut,
    output logic      [PINS_W-1:0] portBOe,
    // Unit two pins (first four pins of port A)
    input  wire logic [PINS_W-1:0] portAIn,
    output logic      [PINS_W-1:0] portAOut,
    output logic      [PINS_W-1:0] portAOe,
    // Engine side, index 0 is unit one, index 1 is unit two
    input  wire logic [1:0]        engDataOut,
    input  wire logic [1:0]        engClkOut,
    input  wire logic [1:0]        engRtsN,
    input  wire logic [1:0]        engSdaLow,
    input  wire logic [1:0]        engSclLow,
    input  wire logic [DATA_W-1:0] engRxData0,
    input  wire logic [DATA_W-1:0] engRxData1,
    output logic      [1:0]        engDataIn,
    output logic      [1:0]        engClkIn,
    output logic      [1:0]        engSelN,
    output logic      [1:0]        engCtsN,
    output logic      [1:0]        engSdaIn,
    output logic      [1:0]        engSclIn,
    output logic      [MODE_W-1:0] engMode0,
    output logic      [MODE_W-1:0] engMode1,
    output logic      [1:0]        engSlave,
    output logic      [1:0]        engFifoDmaEn,
    output logic      [1:0]        engRxLevel,
    output logic      [1:0]        engTxFreeLevel,
    output logic      [1:0]        engTxIdleLevel,
    output logic      [1:0]        engTxWrite,
    output logic      [DATA_W-1:0] engTxData0,
    output logic      [DATA_W-1:0] engTxData1
);

    // ---------------- Register state ----------------
    personality_e      mode_r   [2];   // Mode per unit
    personality_e      mode_nxt [2];
    logic [CFG_W-1:0]  cfg_r    [2];   // Own config per unit
    logic [CFG_W-1:0]  cfg_nxt  [2];
    logic [DATA_W-1:0] tx_r     [2];   // Polled transmit byte
    logic [DATA_W-1:0] tx_nxt   [2];
    logic [1:0]        txWr_r;         // One-cycle write strobe
    logic [1:0]        txWr_nxt;

    // ---------------- Bus state ----------------
    logic [31:0] awAddr_r;     // Captured write address
    logic [31:0] awAddr_nxt;
    logic        awHave_r;     // Write address held
    logic        awHave_nxt;
    logic [7:0]  wByte_r;      // Only byte lane 0 carries fields
    logic [7:0]  wByte_nxt;
    logic        wLane_r;      // Lane 0 strobe seen
    logic        wLane_nxt;
    logic        wHave_r;      // Write data held
    logic        wHave_nxt;
    logic        bValid_r;
    logic        bValid_nxt;
    logic [1:0]  bResp_r;
    logic [1:0]  bResp_nxt;
    logic        rValid_r;
    logic        rValid_nxt;
    logic [1:0]  rResp_r;
    logic [1:0]  rResp_nxt;
    logic [31:0] rData_r;
    logic [31:0] rData_nxt;

    // Write fires once both halves are held and no response pends
    logic doWrite;
    assign doWrite = awHave_r && wHave_r && !bValid_r;

    // Write decode: which word, if any, is hit
    logic       hitMode [2];
    logic       hitCfg  [2];
    logic       hitData [2];
    logic       wMapped;

    always_comb begin
        hitMode[0] = 1'b0;
        hitMode[1] = 1'b0;
        hitCfg[0]  = 1'b0;
        hitCfg[1]  = 1'b0;
        hitData[0] = 1'b0;
        hitData[1] = 1'b0;
        wMapped    = 1'b1;
        if (awAddr_r == ADDR_ONE_MODE) begin
            hitMode[0] = 1'b1;
        end else if (awAddr_r == ADDR_TWO_MODE) begin
            hitMode[1] = 1'b1;
        end else if (awAddr_r == ADDR_ONE_CFG) begin
            hitCfg[0] = 1'b1;
        end else if (awAddr_r == ADDR_TWO_CFG) begin
            hitCfg[1] = 1'b1;
        end else if (awAddr_r == ADDR_ONE_DATA) begin
            hitData[0] = 1'b1;
        end else if (awAddr_r == ADDR_TWO_DATA) begin
            hitData[1] = 1'b1;
        end else begin
            wMapped = 1'b0;
        end
    end

    // FIFO/DMA granted only in SPI and UART personalities
    logic [1:0] fifoOk;
    always_comb begin
        for (int u = 0; u < 2; u++) begin
            fifoOk[u] = cfg_r[u][CFG_FIFODMA] &&
                        (mode_r[u] == PERS_SPI || mode_r[u] == PERS_UART);
        end
    end

    // Write channel next state
    always_comb begin
        awAddr_nxt = awAddr_r;
        awHave_nxt = awHave_r;
        wByte_nxt  = wByte_r;
        wLane_nxt  = wLane_r;
        wHave_nxt  = wHave_r;
        bValid_nxt = bValid_r;
        bResp_nxt  = bResp_r;
        // Address and data are taken in either order
        if (s_axi_awvalid && !awHave_r) begin
            awAddr_nxt = s_axi_awaddr;
            awHave_nxt = 1'b1;
        end
        if (s_axi_wvalid && !wHave_r) begin
            wByte_nxt = s_axi_wdata[7:0];
            wLane_nxt = s_axi_wstrb[0];
            wHave_nxt = 1'b1;
        end
        if (doWrite) begin
            awHave_nxt = 1'b0;
            wHave_nxt  = 1'b0;
            bValid_nxt = 1'b1;
            bResp_nxt  = wMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bValid_r && s_axi_bready) begin
            bValid_nxt = 1'b0;
        end
        if (!rst_n) begin
            awAddr_nxt = '0;
            awHave_nxt = 1'b0;
            wByte_nxt  = '0;
            wLane_nxt  = 1'b0;
            wHave_nxt  = 1'b0;
            bValid_nxt = 1'b0;
            bResp_nxt  = RESP_OKAY;
        end
    end

    always_ff @(posedge clk) begin
        awAddr_r <= awAddr_nxt;
        awHave_r <= awHave_nxt;
        wByte_r  <= wByte_nxt;
        wLane_r  <= wLane_nxt;
        wHave_r  <= wHave_nxt;
        bValid_r <= bValid_nxt;
        bResp_r  <= bResp_nxt;
    end

    // Register file next state; one set per unit
    always_comb begin
        for (int u = 0; u < 2; u++) begin
            mode_nxt[u] = mode_r[u];
            cfg_nxt[u]  = cfg_r[u];
            tx_nxt[u]   = tx_r[u];
            txWr_nxt[u] = 1'b0;
            if (doWrite && wLane_r) begin
                if (hitMode[u]) begin
                    // UART code on unit two falls back to off
                    if (u == 1 && wByte_r[MODE_W-1:0] == PERS_UART) begin
                        mode_nxt[u] = PERS_OFF;
                    end else begin
                        mode_nxt[u] = personality_e'(wByte_r[MODE_W-1:0]);
                    end
                end
                if (hitCfg[u]) begin
                    cfg_nxt[u] = wByte_r[CFG_W-1:0];
                end
                // Polled transmit; ignored while the unit is off
                if (hitData[u] && mode_r[u] != PERS_OFF) begin
                    tx_nxt[u]   = wByte_r;
                    txWr_nxt[u] = 1'b1;
                end
            end
            if (!rst_n) begin
                mode_nxt[u] = personality_e'(MODE_RST);
                cfg_nxt[u]  = CFG_RST;
                tx_nxt[u]   = DATA_RST;
                txWr_nxt[u] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        mode_r <= mode_nxt;
        cfg_r  <= cfg_nxt;
        tx_r   <= tx_nxt;
        txWr_r <= txWr_nxt;
    end

    // Read channel next state; answer one cycle after the address
    always_comb begin
        rValid_nxt = rValid_r;
        rResp_nxt  = rResp_r;
        rData_nxt  = rData_r;
        if (s_axi_arvalid && !rValid_r) begin
            rValid_nxt = 1'b1;
            rResp_nxt  = RESP_OKAY;
            rData_nxt  = '0;
            if (s_axi_araddr == ADDR_ONE_MODE) begin
                rData_nxt[MODE_W-1:0] = mode_r[0];
            end else if (s_axi_araddr == ADDR_TWO_MODE) begin
                rData_nxt[MODE_W-1:0] = mode_r[1];
            end else if (s_axi_araddr == ADDR_ONE_CFG) begin
                rData_nxt[CFG_W-1:0]  = cfg_r[0];
                rData_nxt[STAT_FIFODMA] = fifoOk[0];
            end else if (s_axi_araddr == ADDR_TWO_CFG) begin
                rData_nxt[CFG_W-1:0]  = cfg_r[1];
                rData_nxt[STAT_FIFODMA] = fifoOk[1];
            end else if (s_axi_araddr == ADDR_ONE_DATA) begin
                rData_nxt[DATA_W-1:0] = engRxData0;
            end else if (s_axi_araddr == ADDR_TWO_DATA) begin
                rData_nxt[DATA_W-1:0] = engRxData1;
            end else begin
                rResp_nxt = RESP_SLVERR;
            end
        end else if (rValid_r && s_axi_rready) begin
            rValid_nxt = 1'b0;
        end
        if (!rst_n) begin
            rValid_nxt = 1'b0;
            rResp_nxt  = RESP_OKAY;
            rData_nxt  = '0;
        end
    end

    always_ff @(posedge clk) begin
        rValid_r <= rValid_nxt;
        rResp_r  <= rResp_nxt;
        rData_r  <= rData_nxt;
    end

    // Ready terms come from flops, so they hold the bus rules
    assign s_axi_awready = !awHave_r;
    assign s_axi_wready  = !wHave_r;
    assign s_axi_bvalid  = bValid_r;
    assign s_axi_bresp   = bResp_r;
    assign s_axi_arready = !rValid_r;
    assign s_axi_rvalid  = rValid_r;
    assign s_axi_rresp   = rResp_r;
    assign s_axi_rdata   = rData_r;

    // ---------------- Pin side ----------------
    logic [2*PINS_W-1:0] pinSync;   // Port B pins low, port A pins high

    pin_sync #(
        .W (2*PINS_W)
    ) u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .asyncIn ({portAIn, portBIn}),
        .syncOut (pinSync)
    );

    pin_route_if rt [2] ();

    // Feed each unit's route from its own registers and engine
    for (genvar u = 0; u < 2; u++) begin : g_unit
        assign rt[u].pers    = mode_r[u];
        assign rt[u].slave   = cfg_r[u][CFG_SLAVE];
        assign rt[u].flowEn  = cfg_r[u][CFG_FLOW];
        assign rt[u].dataOut = engDataOut[u];
        assign rt[u].clkOut  = engClkOut[u];
        assign rt[u].rtsN    = engRtsN[u];
        assign rt[u].sdaLow  = engSdaLow[u];
        assign rt[u].sclLow  = engSclLow[u];
        assign rt[u].pinIn   = pinSync[u*PINS_W +: PINS_W];

        unit_pin_mux #(
            .UART_OK  (u == 0),
            .TWI_BASE (u)
        ) u_mux (
            .rt (rt[u])
        );
    end

    // Registered pin and engine outputs
    logic [PINS_W-1:0] pbOut_r;
    logic [PINS_W-1:0] pbOe_r;
    logic [PINS_W-1:0] paOut_r;
    logic [PINS_W-1:0] paOe_r;
    logic [5:0]        engIn_r  [2];   // Data, clk, sel, cts, sda, scl
    logic [PINS_W-1:0] pbOut_nxt;
    logic [PINS_W-1:0] pbOe_nxt;
    logic [PINS_W-1:0] paOut_nxt;
    logic [PINS_W-1:0] paOe_nxt;
    logic [5:0]        engIn_nxt [2];

    // One cycle of pipeline keeps every output on a flop
    always_comb begin
        pbOut_nxt = rt[0].pinOut;
        pbOe_nxt  = rt[0].pinOe;
        paOut_nxt = rt[1].pinOut;
        paOe_nxt  = rt[1].pinOe;
        engIn_nxt[0] = {rt[0].dataIn, rt[0].clkIn, rt[0].selN,
                        rt[0].ctsN, rt[0].sdaIn, rt[0].sclIn};
        engIn_nxt[1] = {rt[1].dataIn, rt[1].clkIn, rt[1].selN,
                        rt[1].ctsN, rt[1].sdaIn, rt[1].sclIn};
        if (!rst_n) begin
            // Pins released during reset
            pbOut_nxt    = '0;
            pbOe_nxt     = '0;
            paOut_nxt    = '0;
            paOe_nxt     = '0;
            engIn_nxt[0] = 6'h2F;
            engIn_nxt[1] = 6'h2F;
        end
    end

    always_ff @(posedge clk) begin
        pbOut_r <= pbOut_nxt;
        pbOe_r  <= pbOe_nxt;
        paOut_r <= paOut_nxt;
        paOe_r  <= paOe_nxt;
        engIn_r <= engIn_nxt;
    end

    assign portBOut = pbOut_r;
    assign portBOe  = pbOe_r;
    assign portAOut = paOut_r;
    assign portAOe  = paOe_r;

    // Engine-facing fields, straight from registers
    for (genvar u = 0; u < 2; u++) begin : g_eng
        assign engDataIn[u]      = engIn_r[u][5];
        assign engClkIn[u]       = engIn_r[u][4];
        assign engSelN[u]        = engIn_r[u][3];
        assign engCtsN[u]        = engIn_r[u][2];
        assign engSdaIn[u]       = engIn_r[u][1];
        assign engSclIn[u]       = engIn_r[u][0];
        assign engSlave[u]       = cfg_r[u][CFG_SLAVE];
        assign engRxLevel[u]     = cfg_r[u][CFG_RXLVL];
        assign engTxFreeLevel[u] = cfg_r[u][CFG_TXFRLVL];
        assign engTxIdleLevel[u] = cfg_r[u][CFG_TXIDLVL];
        assign engTxWrite[u]     = txWr_r[u];
    end

    // FIFO/DMA grant registered for a clean output
    logic [1:0] fifo_r;
    logic [1:0] fifo_nxt;
    always_comb begin
        fifo_nxt = rst_n ? fifoOk : 2'h0;
    end
    always_ff @(posedge clk) begin
        fifo_r <= fifo_nxt;
    end
    assign engFifoDmaEn = fifo_r;

    assign engMode0   = mode_r[0];
    assign engMode1   = mode_r[1];
    assign engTxData0 = tx_r[0];
    assign engTxData1 = tx_r[1];

endmodule

// ---- sim/serial_controller_mode_select_chk.sv ----
// Purpose: Pin routing assertions for the mode selector
// Assumes: Mode settles for three edges before pins are judged
// Notes:   Bound to the top module
`timescale 1ns/1ps
module mode_sel_chk
    import serial_mode_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [PINS_W-1:0] portBOut,
    input wire logic [PINS_W-1:0] portBOe,
    input wire logic [PINS_W-1:0] portAOut,
    input wire logic [PINS_W-1:0] portAOe,
    input wire logic [MODE_W-1:0] engMode0,
    input wire logic [MODE_W-1:0] engMode1,
    input wire logic [1:0]        engSlave
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // History of mode and slave bit, pins lag the register
    logic [2:0] h_r;
    logic [2:0] g_r;
    wire  [2:0] cur = {engSlave[0], engMode0};
    wire        st  = cur == h_r && cur == g_r;
    always_ff @(posedge clk) begin
        h_r <= cur;
        g_r <= h_r;
    end
    property p_off; st && engMode0 == PERS_OFF |-> portBOe == 4'h0; endproperty
    a_off: assert property (p_off) else $error("unit one drives while off");
    property p_nouart; engMode1 != PERS_UART; endproperty
    a_nouart: assert property (p_nouart) else $error("unit two in uart");
    property p_spim; st && cur == 3'h2 |-> portBOe == 4'h5 ##1 portBOe == 4'h5; endproperty
    a_spim: assert property (p_spim) else $error("unit one master pins");
    property p_spis; st && cur == 3'h6 |-> portBOe == 4'h1; endproperty
    a_spis: assert property (p_spis) else $error("unit one slave pins");
    property p_twi; st && engMode0 == PERS_TWI |-> portBOut[1:0] == 2'h0 && !portBOe[3:2]; endproperty
    a_twi: assert property (p_twi) else $error("unit one two-wire pins");
    property p_uart; st && engMode0 == PERS_UART |-> portBOe[2:0] == 3'h1; endproperty
    a_uart: assert property (p_uart) else $error("unit one uart pins");
    property p_spim2; (engMode1 == PERS_SPI && !engSlave[1])[*3] |-> portAOe == 4'h5; endproperty
    a_spim2: assert property (p_spim2) else $error("unit two master pins");
    property p_twi2; (engMode1 == PERS_TWI)[*3] |-> !portAOe[0] && !portAOe[3] && !portAOut[2:1];
    endproperty
    a_twi2: assert property (p_twi2) else $error("unit two two-wire pins");
endmodule
bind serial_controller_mode_select mode_sel_chk chk_u (.*);

// ---- sim/serial_peer.sv ----
// Purpose: Far-side peer on one four-pin group
// Assumes: Bench picks the levels the peer presents
// Notes:   Design drive wins where its enable is high
`timescale 1ns/1ps
module serial_peer (
    input  wire logic [3:0] pinOut,
    input  wire logic [3:0] pinOe,
    input  wire logic [3:0] drv,
    output logic      [3:0] pinIn
);
    // Peer gives clock, select and CTS on undriven pins
    assign pinIn = (pinOe & pinOut) | (~pinOe & drv);
endmodule

// ---- sim/serial_controller_mode_select_test.sv ----
// Purpose: Self-checking bench for the serial mode selector
// Assumes: Peers stand on both pin groups
// Notes:   Registers reached over AXI4-Lite only
`timescale 1ns/1ps
module serial_controller_mode_select_test;
    import serial_mode_pkg::*;
    logic clk = 0, rst_n = 0, awV = 0, wV = 0, bRdy = 0, arV = 0, rRdy = 0;
    logic [31:0] awA = 0, wD = 0, arA = 0;
    logic [3:0] drvB = 4'h5, drvA = 4'h5;
    logic [1:0] dO = 2'h1, sL = 2'h1, kL = 2'h2;
    int mismatches = 0, comparisons = 0;
    wire awR, wR, bV, arR, rV;
    wire [1:0] bRsp, rRsp, din, seln, m1, gnt, rxl, txf, txi;
    wire [31:0] rD;
    wire [3:0] pB, pA, bO, bOe, aO, aOe;
    wire [7:0] tx0;
    serial_peer peerB (.pinOut(bO), .pinOe(bOe), .drv(drvB), .pinIn(pB));
    serial_peer peerA (.pinOut(aO), .pinOe(aOe), .drv(drvA), .pinIn(pA));
    serial_controller_mode_select dut_u (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awA),
        .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bRsp), .s_axi_bvalid(bV),
        .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR),
        .s_axi_rdata(rD), .s_axi_rresp(rRsp), .s_axi_rvalid(rV), .s_axi_rready(rRdy),
        .portBIn(pB), .portBOut(bO), .portBOe(bOe), .portAIn(pA), .portAOut(aO),
        .portAOe(aOe), .engDataOut(dO), .engClkOut(2'h0), .engRtsN(2'h3), .engSdaLow(sL),
        .engSclLow(kL), .engRxData0(8'hC3), .engRxData1(8'h00), .engDataIn(din),
        .engClkIn(), .engSelN(seln), .engCtsN(), .engSdaIn(), .engSclIn(), .engMode0(),
        .engMode1(m1), .engSlave(), .engFifoDmaEn(gnt), .engRxLevel(rxl),
        .engTxFreeLevel(txf), .engTxIdleLevel(txi), .engTxWrite(), .engTxData0(tx0),
        .engTxData1());
    always #20 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask
    // Handshakes judged on settled pre-edge values
    task automatic wr(input logic [31:0] a, d);
        logic ta, tw, tb;
        logic [1:0] g;
        @(posedge clk);
        {awA, wD, awV, wV, bRdy} <= {a, d, 3'h7};
        do begin
            #1 {ta, tw, tb, g} = {awR & awV, wR & wV, bV, bRsp};
            @(posedge clk);
            if (ta) awV <= 0;
            if (tw) wV <= 0;
        end while (!tb);
        bRdy <= 0;
        chk("bresp", 32'(RESP_OKAY), 32'(g));
    endtask
    task automatic rd(input logic [31:0] a, e, input logic [1:0] r = RESP_OKAY);
        logic ta, tr;
        logic [31:0] g;
        logic [1:0] gr;
        @(posedge clk);
        {arA, arV, rRdy} <= {a, 2'h3};
        do begin
            #1 {ta, tr, g, gr} = {arR & arV, rV, rD, rRsp};
            @(posedge clk);
            if (ta) arV <= 0;
        end while (!tr);
        rRdy <= 0;
        chk("rdata", e, g);
        chk("rresp", 32'(r), 32'(gr));
    endtask
    // Unit one through every personality, setup before mode
    task automatic t_unit1();
        logic [3:0] cf [5] = '{4'h4, 4'h4, 4'h5, 4'h4, 4'h6};
        logic [1:0] md [5] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h1};
        logic [3:0] oe [5] = '{4'h0, 4'h5, 4'h1, 4'h1, 4'h9};
        logic [2:0] gd [5] = '{3'h3, 3'h6, 3'h4, 3'h3, 3'h6};
        rd(ADDR_ONE_MODE, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_ONE_CFG, 32'(cf[i]));
            wr(ADDR_ONE_MODE, 32'(md[i]));
            rd(ADDR_ONE_MODE, 32'(md[i]));
            rd(ADDR_ONE_CFG, {23'h0, gd[i][2], 4'h0, cf[i]});
            #1 chk("oeB", 32'(oe[i]), 32'(bOe));
            chk("gnt", 32'(gd[i][2]), 32'(gnt[0]));
            chk("sel", 32'(gd[i][1]), 32'(seln[0]));
            if (md[i] != 2'h3) chk("din", 32'(gd[i][0]), 32'(din[0]));
        end
    endtask
    task automatic t_unit2();
        logic [3:0] oa [4] = '{4'h0, 4'h0, 4'h5, 4'h4};
        rd(ADDR_TWO_MODE, 32'h0);
        for (int i = 1; i < 4; i++) begin
            wr(ADDR_TWO_MODE, 32'(i));
            rd(ADDR_TWO_MODE, (i == 1) ? 32'h0 : 32'(i));
            #1 chk("oeA", 32'(oa[i]), 32'(aOe));
        end
        chk("oeB", 32'h9, 32'(bOe));
        chk("m1", 32'h3, 32'(m1));
    endtask
    task automatic t_misc();
        wr(ADDR_ONE_DATA, 32'hA5);
        rd(ADDR_ONE_DATA, 32'hC3);
        #1 chk("tx", 32'hA5, 32'(tx0));
        wr(ADDR_ONE_CFG, 32'h38);
        rd(ADDR_ONE_CFG, 32'h38);
        #1 chk("lvl", 32'h7, 32'({rxl[0], txf[0], txi[0]}));
        rd(32'h4000_C000, 32'h0, RESP_SLVERR);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        t_unit1();
        t_unit2();
        t_misc();
        final_report();
    end
    initial begin
        #100000;
        mismatches++;
        final_report();
    end
endmodule
